// ==== hdl/nbp_host_ctrl.sv ====
/*
  Host controller for the block-protection commands of a NAND device:
  volatile range unlock, lock-all, lock-down, permanent group protect and
  lock-down, protection status read and write-protect pulse.
  Assumes the NAND pins are wired directly and i_ready_busy is asynchronous.
*/
`timescale 1ns/1ps
`include "nbp_cfg.svh"

module nbp_host_ctrl #(
  parameter int MAX_ATTEMPTS = `NBP_MAX_ATTEMPTS
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_req_valid,
  input  wire nbp_pkg::nbp_op_t i_req_op,
  input  wire logic [12:0]      i_lower_bound,
  input  wire logic [12:0]      i_upper_bound,
  input  wire logic             i_range_invert_bit,
  input  wire logic [3:0]       i_group_select,
  input  wire logic             i_ready_busy,
  input  wire logic [7:0]       i_io_in,
  output logic                  o_busy,
  output logic                  o_done,
  output logic                  o_refused,
  output logic [7:0]            o_block_lock_state,
  output logic                  o_state_valid,
  output logic                  o_ce_n,
  output logic                  o_cle,
  output logic                  o_ale,
  output logic                  o_we_n,
  output logic                  o_re_n,
  output logic [7:0]            o_io_out,
  output logic                  o_io_oe,
  output logic                  o_write_protect_n,
  output logic                  o_volatile_protect_enable
);
  import nbp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_CYCLE, ST_WAIT_WB, ST_WAIT_RB, ST_WP_LOW
  } nbp_st_t;

  typedef struct packed {
    nbp_st_t     st;
    nbp_op_t     op;
    logic [4:0]  step;
    logic [12:0] lo;
    logic [12:0] up;
    logic        inv;
    logic [3:0]  grp;
    logic [2:0]  cnt;
    logic [4:0]  attempts;
    logic [15:0] grp_done;
    logic        perm_locked;
    logic        wp_n;
    logic        volatile_protect_enable_pin;
    logic        busy;
    logic        done;
    logic        refused;
    logic [7:0]  block_lock_state;
    logic        bls_valid;
    logic        rb_s1;
    logic        rb_s2;
    logic        pc_start;
    nbp_kind_t   pc_kind;
    logic [7:0]  pc_byte;
    logic        saw_lo;
    logic [7:0]  last_cmd;
    logic        ce_n;
  } nbp_st_s_t;

  nbp_st_s_t s_r, s_nxt;
  logic [7:0] pc_rd_data;
  logic       pc_done;
  logic       pc_idle;

  ////////////////////////////////////////////////////////////////////////
  // Address byte n of a block address
  function automatic logic [7:0] addr_byte(input logic [12:0] ba, input logic [1:0] n,
                                           input logic inv);
    logic [7:0] b;
    b = 8'h00;
    unique case (n)
      2'd0:    b = {ba[1], ba[0], 5'h00, inv};
      2'd1:    b = ba[9:2];
      default: b = {5'h00, ba[12:10]};
    endcase
    return b;
  endfunction

  // One step of a sequence: kind and byte
  function automatic logic [10:0] seq_step(input nbp_op_t op, input logic [4:0] idx,
                                           input logic [12:0] lo, input logic [12:0] up,
                                           input logic inv, input logic [3:0] g);
    nbp_kind_t  k;
    logic [7:0] b;
    logic [1:0] n;
    k = NBP_K_END;
    b = 8'h00;
    n = idx[1:0] - 2'd1;
    unique case (op)
      NBP_OP_UNLOCK: begin
        // Lower bound first, then upper with the invert bit
        if (idx == 5'd0) begin
          k = NBP_K_CMD; b = `NBP_CMD_UNLOCK_LO;
        end else if (idx <= 5'd3) begin
          k = NBP_K_ADDR; b = addr_byte(lo, n, 1'b0);
        end else if (idx == 5'd4) begin
          k = NBP_K_CMD; b = `NBP_CMD_UNLOCK_UP;
        end else if (idx <= 5'd7) begin
          k = NBP_K_ADDR; b = addr_byte(up, n, inv);
        end
      end
      NBP_OP_LOCK_ALL: if (idx == 5'd0) begin
        k = NBP_K_CMD; b = `NBP_CMD_LOCK_ALL;
      end
      NBP_OP_LOCKDOWN: if (idx == 5'd0) begin
        k = NBP_K_CMD; b = `NBP_CMD_LOCK_DOWN;
      end
      NBP_OP_PERM, NBP_OP_PERM_LD: begin
        // Entry, 80h, addresses, 10h, busy wait, reset
        unique case (idx)
          5'd0: begin k = NBP_K_CMD;  b = `NBP_CMD_ENTRY1; end
          5'd1: begin k = NBP_K_CMD;  b = `NBP_CMD_ENTRY2; end
          5'd2: begin k = NBP_K_CMD;  b = `NBP_CMD_ENTRY3; end
          5'd3: begin k = NBP_K_CMD;  b = `NBP_CMD_ENTRY4; end
          5'd4: begin k = NBP_K_CMD;  b = `NBP_CMD_PROG;   end
          5'd5, 5'd6, 5'd7: begin k = NBP_K_ADDR; b = `NBP_ADDR_ZERO; end
          5'd8: begin
            k = NBP_K_ADDR;
            b = {(op == NBP_OP_PERM_LD) ? `NBP_LD_NIBBLE : `NBP_PERM_NIBBLE, g};
          end
          5'd9: begin
            k = (op == NBP_OP_PERM_LD) ? NBP_K_ADDR : NBP_K_CMD;
            b = (op == NBP_OP_PERM_LD) ? `NBP_ADDR_ZERO : `NBP_CMD_CONFIRM;
          end
          5'd10: begin
            k = (op == NBP_OP_PERM_LD) ? NBP_K_CMD : NBP_K_WAIT;
            b = `NBP_CMD_CONFIRM;
          end
          5'd11: begin
            k = (op == NBP_OP_PERM_LD) ? NBP_K_WAIT : NBP_K_CMD;
            b = `NBP_CMD_RESET;
          end
          5'd12: if (op == NBP_OP_PERM_LD) begin
            k = NBP_K_CMD; b = `NBP_CMD_RESET;
          end
          default: k = NBP_K_END;
        endcase
      end
      NBP_OP_STATUS: begin
        // Command, three addresses with the invert bit low, one data read
        if (idx == 5'd0) begin
          k = NBP_K_CMD; b = `NBP_CMD_STATUS;
        end else if (idx <= 5'd3) begin
          k = NBP_K_ADDR; b = addr_byte(lo, n, 1'b0);
        end else if (idx == 5'd4) begin
          k = NBP_K_READ;
        end
      end
      default: k = NBP_K_END;
    endcase
    return {k, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [10:0] e;
    e             = seq_step(s_r.op, s_r.step, s_r.lo, s_r.up, s_r.inv, s_r.grp);
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.bls_valid = 1'b0;
    s_nxt.pc_start  = 1'b0;
    s_nxt.rb_s1   = i_ready_busy;  // Pin synchroniser, first stage
    s_nxt.rb_s2   = s_r.rb_s1;
    unique case (s_r.st)
      ST_IDLE: begin
        if (i_req_valid) begin
          s_nxt.op   = i_req_op;
          s_nxt.lo   = i_lower_bound;
          s_nxt.up   = i_upper_bound;
          s_nxt.inv  = i_range_invert_bit;
          s_nxt.grp  = i_group_select;
          s_nxt.step = 5'd0;
          s_nxt.cnt  = 3'd0;
          if ((i_req_op == NBP_OP_PERM || i_req_op == NBP_OP_PERM_LD) &&
              (s_r.attempts >= 5'(MAX_ATTEMPTS) || s_r.perm_locked ||
               s_r.grp_done[i_group_select])) begin
            s_nxt.refused = 1'b1;
          end else if (i_req_op == NBP_OP_WP_PULSE) begin
            s_nxt.wp_n = 1'b0;
            s_nxt.busy = 1'b1;
            s_nxt.st   = ST_WP_LOW;
          end else begin
            if (i_req_op == NBP_OP_PERM || i_req_op == NBP_OP_PERM_LD) begin
              s_nxt.attempts = s_r.attempts + 5'd1;
              s_nxt.grp_done[i_group_select] = 1'b1;
              s_nxt.perm_locked = (i_req_op == NBP_OP_PERM_LD);
            end
            s_nxt.busy = 1'b1;
            s_nxt.st   = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        unique case (nbp_kind_t'(e[10:8]))
          NBP_K_WAIT: s_nxt.st = ST_WAIT_WB;
          NBP_K_END: begin
            s_nxt.busy   = 1'b0;
            s_nxt.done   = 1'b1;
            s_nxt.saw_lo = 1'b0;
            s_nxt.st     = ST_IDLE;
          end
          default: begin
            s_nxt.pc_start = 1'b1;
            s_nxt.pc_kind  = nbp_kind_t'(e[10:8]);
            s_nxt.pc_byte  = e[7:0];
            if (nbp_kind_t'(e[10:8]) == NBP_K_CMD) begin
              s_nxt.last_cmd = e[7:0];
              if (e[7:0] == `NBP_CMD_UNLOCK_LO) begin
                s_nxt.saw_lo = 1'b1;
              end
            end
            s_nxt.st = ST_CYCLE;
          end
        endcase
      end
      ST_CYCLE: begin
        if (pc_done) begin
          if (s_r.pc_kind == NBP_K_READ) begin
            s_nxt.block_lock_state       = pc_rd_data;
            s_nxt.bls_valid = 1'b1;
          end
          s_nxt.step = s_r.step + 5'd1;
          s_nxt.st   = ST_ISSUE;
        end
      end
      ST_WAIT_WB: begin
        // Let the device pull ready_busy_out low before watching it
        if (s_r.cnt == 3'(`NBP_TWB_CYC - 1)) begin
          s_nxt.st = ST_WAIT_RB;
        end else begin
          s_nxt.cnt = s_r.cnt + 3'd1;
        end
      end
      ST_WAIT_RB: begin
        if (s_r.rb_s2) begin
          s_nxt.step = s_r.step + 5'd1;
          s_nxt.st   = ST_ISSUE;
        end
      end
      ST_WP_LOW: begin
        if (s_r.cnt == 3'(`NBP_WP_LOW_CYC - 1)) begin
          s_nxt.wp_n = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st   = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + 3'd1;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    s_nxt.ce_n = !s_nxt.busy;  // Chip enable registered from next busy
  end

  // State register; pins idle with protect and enable high
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.op    <= NBP_OP_LOCK_ALL;
      s_r.wp_n  <= 1'b1;
      s_r.volatile_protect_enable_pin   <= 1'b1;
      s_r.rb_s1 <= 1'b1;
      s_r.rb_s2 <= 1'b1;
      s_r.ce_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus cycle engine
  nbp_pin_cycle u_pin (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_start   (s_r.pc_start),
    .i_kind    (s_r.pc_kind),
    .i_byte    (s_r.pc_byte),
    .i_io_in   (i_io_in),
    .o_cle     (o_cle),
    .o_ale     (o_ale),
    .o_we_n    (o_we_n),
    .o_re_n    (o_re_n),
    .o_io_out  (o_io_out),
    .o_io_oe   (o_io_oe),
    .o_rd_data (pc_rd_data),
    .o_done    (pc_done),
    .o_idle    (pc_idle)
  );

  assign o_busy                    = s_r.busy;
  assign o_done                    = s_r.done;
  assign o_refused                 = s_r.refused;
  assign o_block_lock_state        = s_r.block_lock_state;
  assign o_state_valid             = s_r.bls_valid;
  assign o_ce_n                    = s_r.ce_n;
  assign o_write_protect_n         = s_r.wp_n;
  assign o_volatile_protect_enable = s_r.volatile_protect_enable_pin;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_upper_after_lower: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.pc_byte == `NBP_CMD_UNLOCK_UP && s_r.pc_kind == NBP_K_CMD)
      |-> s_r.saw_lo)
    else $error("upper bound command without lower bound command");

  chk_status_addr_low: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.op == NBP_OP_STATUS && s_r.step == 5'd1) |-> !s_r.pc_byte[0])
    else $error("status address carries a set invert bit");

  chk_lockdown_pins: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.pc_byte == `NBP_CMD_LOCK_DOWN && s_r.pc_kind == NBP_K_CMD)
      |-> (o_write_protect_n && o_volatile_protect_enable)[*3])
    else $error("lock-down issued without protect pins high");

  chk_reset_not_busy: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.pc_byte == `NBP_CMD_RESET) |-> $past(s_r.rb_s2, 2))
    else $error("reset sent while device busy");

  chk_perm_ends_reset: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.done && (s_r.op == NBP_OP_PERM || s_r.op == NBP_OP_PERM_LD) && !o_write_protect_n == 1'b0)
      |-> s_r.last_cmd == `NBP_CMD_RESET)
    else $error("permanent sequence not ended by reset");

  chk_attempt_limit: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.attempts <= 5'(MAX_ATTEMPTS)) and
    ((i_req_valid && s_r.st == ST_IDLE && i_req_op == NBP_OP_PERM &&
      s_r.grp_done[i_group_select]) |=> o_refused))
    else $error("permanent attempt limit or group reuse broken");

  chk_vpe_held: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && (s_r.op == NBP_OP_UNLOCK || s_r.op == NBP_OP_LOCK_ALL ||
                      s_r.op == NBP_OP_LOCKDOWN)) |-> o_volatile_protect_enable)
    else $error("volatile command with enable low");

  chk_status_read: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.pc_kind == NBP_K_READ) |-> (s_r.op == NBP_OP_STATUS && s_r.step == 5'd4))
    else $error("data read outside status read");

  chk_group_byte: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (s_r.pc_start && s_r.op == NBP_OP_PERM && s_r.step == 5'd8)
      |-> (s_r.pc_kind == NBP_K_ADDR && s_r.pc_byte == {4'h0, s_r.grp}))
    else $error("wrong group address byte");

  chk_wp_pulse_len: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    $fell(o_write_protect_n) |-> !o_write_protect_n[*4] ##1 o_write_protect_n)
    else $error("write protect pulse length wrong");

  chk_engine_idle: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    s_r.pc_start |-> pc_idle)
    else $error("bus cycle started while engine busy");

endmodule

// ==== hdl/nbp_cfg.svh ====
/*
  Constants of the NAND block-protection host controller: command codes,
  address field positions and pin timing counts.
  Assumes a 25 MHz system clock and a NAND device on the other side.
*/
`ifndef NBP_CFG_SVH
`define NBP_CFG_SVH

// Command codes
`define NBP_CMD_UNLOCK_LO  8'h23
`define NBP_CMD_UNLOCK_UP  8'h24
`define NBP_CMD_LOCK_ALL   8'h2a
`define NBP_CMD_LOCK_DOWN  8'h2c
`define NBP_CMD_STATUS     8'h7a
`define NBP_CMD_ENTRY1     8'h4c
`define NBP_CMD_ENTRY2     8'h03
`define NBP_CMD_ENTRY3     8'h1d
`define NBP_CMD_ENTRY4     8'h41
`define NBP_CMD_PROG       8'h80
`define NBP_CMD_CONFIRM    8'h10
`define NBP_CMD_RESET      8'hff
`define NBP_ADDR_ZERO      8'h00

// Address fields
`define NBP_LD_NIBBLE      4'h1
`define NBP_PERM_NIBBLE    4'h0
`define NBP_GROUPS         16
`define NBP_MAX_ATTEMPTS   16

// Timing
`define NBP_CLK_NS         40
`define NBP_WP_LOW_NS      100
`define NBP_TWB_NS         100
`define NBP_WP_LOW_CYC     ((`NBP_WP_LOW_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS + 1)
`define NBP_TWB_CYC        ((`NBP_TWB_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS)
`define NBP_WE_LOW_CYC     1
`define NBP_RE_LOW_CYC     3

`endif

// ==== hdl/nbp_pkg.sv ====
/*
  Types shared by the block-protection host controller and its pin engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nbp_pkg;

  // Requested operations
  typedef enum logic [2:0] {
    NBP_OP_UNLOCK, NBP_OP_LOCK_ALL, NBP_OP_LOCKDOWN, NBP_OP_PERM,
    NBP_OP_PERM_LD, NBP_OP_STATUS, NBP_OP_WP_PULSE
  } nbp_op_t;

  // Kinds of sequence steps
  typedef enum logic [2:0] {
    NBP_K_CMD, NBP_K_ADDR, NBP_K_READ, NBP_K_WAIT, NBP_K_END
  } nbp_kind_t;

endpackage

// ==== hdl/nbp_pin_cycle.sv ====
/*
  Pin engine: performs one command, address or data-read bus cycle on the
  multiplexed NAND pins.
  Assumes the caller holds i_start only while o_idle is high.
*/
`timescale 1ns/1ps
`include "nbp_cfg.svh"

module nbp_pin_cycle (
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  input  wire logic               i_start,
  input  wire nbp_pkg::nbp_kind_t i_kind,
  input  wire logic [7:0]         i_byte,
  input  wire logic [7:0]         i_io_in,
  output logic                    o_cle,
  output logic                    o_ale,
  output logic                    o_we_n,
  output logic                    o_re_n,
  output logic [7:0]              o_io_out,
  output logic                    o_io_oe,
  output logic [7:0]              o_rd_data,
  output logic                    o_done,
  output logic                    o_idle
);
  import nbp_pkg::*;

  typedef enum logic [1:0] {PC_IDLE, PC_SETUP, PC_STROBE, PC_HOLD} nbp_pc_st_t;

  typedef struct packed {
    nbp_pc_st_t st;
    logic       rd;
    logic [1:0] cnt;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io_out;
    logic       io_oe;
    logic [7:0] rd_data;
    logic       done;
    logic [7:0] io_s1;
    logic [7:0] io_s2;
  } nbp_pc_t;

  nbp_pc_t s_r, s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.done  = 1'b0;
    s_nxt.io_s1 = i_io_in;  // Pin synchroniser, first stage
    s_nxt.io_s2 = s_r.io_s1;
    unique case (s_r.st)
      PC_IDLE: begin
        if (i_start) begin
          s_nxt.rd     = (i_kind == NBP_K_READ);
          s_nxt.cle    = (i_kind == NBP_K_CMD);
          s_nxt.ale    = (i_kind == NBP_K_ADDR);
          s_nxt.io_out = i_byte;
          s_nxt.io_oe  = (i_kind != NBP_K_READ);
          s_nxt.st     = PC_SETUP;
        end
      end
      PC_SETUP: begin
        s_nxt.we_n = s_r.rd;
        s_nxt.re_n = !s_r.rd;
        s_nxt.cnt  = 2'd0;
        s_nxt.st   = PC_STROBE;
      end
      PC_STROBE: begin
        // Strobe width; reads wait for the two-stage data synchroniser
        if (s_r.cnt == (s_r.rd ? 2'(`NBP_RE_LOW_CYC - 1) : 2'(`NBP_WE_LOW_CYC - 1))) begin
          if (s_r.rd) begin
            s_nxt.rd_data = s_r.io_s2;
          end
          s_nxt.we_n = 1'b1;
          s_nxt.re_n = 1'b1;
          s_nxt.st   = PC_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt + 2'd1;
        end
      end
      PC_HOLD: begin
        s_nxt.cle   = 1'b0;
        s_nxt.ale   = 1'b0;
        s_nxt.io_oe = 1'b0;
        s_nxt.done  = 1'b1;
        s_nxt.st    = PC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r      <= '0;
      s_r.st   <= PC_IDLE;
      s_r.we_n <= 1'b1;
      s_r.re_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_cle     = s_r.cle;
  assign o_ale     = s_r.ale;
  assign o_we_n    = s_r.we_n;
  assign o_re_n    = s_r.re_n;
  assign o_io_out  = s_r.io_out;
  assign o_io_oe   = s_r.io_oe;
  assign o_rd_data = s_r.rd_data;
  assign o_done    = s_r.done;
  assign o_idle    = (s_r.st == PC_IDLE);

endmodule

// ==== test/nbp_nand_model.sv ====
/*
  Behavioural NAND device model for the block-protection host controller:
  logs command and address bytes, keeps protection flags, answers status reads.
  Assumes the host drives the pins as in the controller's pin engine.
*/
`timescale 1ns/1ps
module nbp_nand_model (
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic [7:0] i_io,
  output logic            o_rb,
  output logic [7:0]      o_io
);
  logic [8:0]  log_q [$];
  logic        unl;
  logic        ld;
  logic        pld;
  logic        inv_r;
  logic        iv;
  logic        blk_unl;
  logic [7:0]  cur;
  logic [2:0]  acnt;
  logic [12:0] a;
  logic [12:0] lb;
  logic [12:0] ub;
  logic [12:0] qa;
  logic [15:0] gp;
  ////////////////////////////////////////////////////////////////////////
  // Power-on state: volatile range locked, nothing locked down
  initial begin
    o_rb = 1'h1;
    o_io = 8'h5a;
    unl = 1'h0;
    ld = 1'h0;
    pld = 1'h0;
    gp = 16'h0000;
    inv_r = 1'h0;
    iv = 1'h0;
    blk_unl = 1'h0;
    cur = 8'h00;
    acnt = 3'h0;
    a = 13'h0000;
    lb = 13'h0000;
    ub = 13'h0000;
    qa = 13'h0000;
  end
  // Latch bytes on the write strobe rising edge
  always @(posedge i_we_n) begin
    if (!i_ce_n && (i_cle || i_ale)) begin
      log_q.push_back({i_cle, i_io});
      if (i_cle) begin
        cur = i_io;
        acnt = 3'h0;
      end
      if (i_cle && !ld && i_io == 8'h2a) unl = 1'h0;
      if (i_cle && i_io == 8'h2c) ld = 1'h1;
      if (i_cle && i_io == 8'h10) begin
        o_rb = 1'h0;
        o_rb <= #600 1'h1;
      end
      if (i_ale) begin
        // Block address: bits 1,0 and invert, bits 9..2, bits 12..10
        if (acnt == 3'h0) begin
          a[1:0] = i_io[7:6];
          iv = i_io[0];
        end
        if (acnt == 3'h1) a[9:2] = i_io;
        if (acnt == 3'h2) a[12:10] = i_io[2:0];
        if (acnt == 3'h2 && cur == 8'h23 && !ld) lb = a;
        if (acnt == 3'h2 && cur == 8'h24 && !ld) begin
          ub = a;
          inv_r = iv;
          unl = 1'h1;
        end
        if (acnt == 3'h2 && cur == 8'h7a) qa = a;
        if (acnt == 3'h3 && cur == 8'h80) begin
          gp[i_io[3:0]] = 1'h1;
          if (i_io[7:4] == 4'h1) pld = 1'h1;
        end
        acnt = acnt + 3'h1;
      end
    end
  end
  // Status of the addressed block while read strobe low, scrambled once released
  always @(negedge i_re_n) begin
    blk_unl = unl && (inv_r ? (qa < lb || qa > ub) : (qa >= lb && qa <= ub));
    o_io = {3'h0, pld, !(qa < 13'h0040 && gp[qa[5:2]]), blk_unl, !ld, ld};
  end
  always @(posedge i_re_n) o_io = ~o_io;
endmodule

// ==== test/test_nbp_host_ctrl.sv ====
/*
  Testbench of the block-protection host controller: issues each request
  and compares pin traffic, refusals and status bytes.
  Assumes the NAND model file is compiled before this one.
*/
`timescale 1ns/1ps
module test_nbp_host_ctrl;
  import nbp_pkg::*;
  logic       i_clk_sys, i_sys_rst, req_valid, inv, rb, done, refused, refd;
  logic       ce_n, cle, ale, we_n, re_n, oe, wp_n, volatile_protect_enable_pin, sv, bsy;
  nbp_op_t    req_op;
  logic [12:0] lo, up;
  logic [3:0] grp;
  logic [7:0] io_out, m_io, lock_st;
  logic [8:0] exp_q [$];
  logic [7:0] ent [5] = '{8'h4c, 8'h03, 8'h1d, 8'h41, 8'h80};
  int         num_errors = 0, total_checks = 0, cyc = 0, wpc = 0, svc = 0, bsc = 0;
  ////////////////////////////////////////////////////////////////////////
  nbp_host_ctrl uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid),
    .i_req_op(req_op), .i_lower_bound(lo), .i_upper_bound(up), .i_range_invert_bit(inv),
    .i_group_select(grp), .i_ready_busy(rb), .i_io_in(oe ? io_out : m_io), .o_busy(bsy),
    .o_done(done), .o_refused(refused), .o_block_lock_state(lock_st), .o_state_valid(sv),
    .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n), .o_io_out(io_out),
    .o_io_oe(oe), .o_write_protect_n(wp_n), .o_volatile_protect_enable(volatile_protect_enable_pin));
  nbp_nand_model dev (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_io(io_out), .o_rb(rb), .o_io(m_io));
  // Clock and hang guard
  initial begin
    i_clk_sys = 1'h0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("[ERR] %0t run timed out", $time);
      wrap_up();
    end
  end
  // Comparison and expectation helpers
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task ex(input logic c, input logic [7:0] b);
    exp_q.push_back({c, b});
  endtask
  task ex_ba(input logic [12:0] ba, input logic iv);
    ex(1'h0, {ba[1:0], 5'h00, iv});
    ex(1'h0, ba[9:2]);
    ex(1'h0, {5'h00, ba[12:10]});
  endtask
  task cmp_log;
    chk(9'(dev.log_q.size()), 9'(exp_q.size()));
    foreach (exp_q[k]) if (k < dev.log_q.size()) chk(dev.log_q[k], exp_q[k]);
    dev.log_q.delete();
    exp_q.delete();
  endtask
  task perm_exp(input logic [3:0] nib);
    foreach (ent[k]) ex(1'h1, ent[k]);
    repeat (3) ex(1'h0, 8'h00);
    ex(1'h0, {nib, grp});
    if (nib == 4'h1) ex(1'h0, 8'h00);
    ex(1'h1, 8'h10);
    ex(1'h1, 8'hff);
  endtask
  // One request, waits for done or refusal
  task run(input nbp_op_t op);
    int n;
    n = 0;
    wpc = 0;
    svc = 0;
    bsc = 0;
    @(posedge i_clk_sys);
    req_valid <= 1'h1;
    req_op <= op;
    @(posedge i_clk_sys);
    req_valid <= 1'h0;
    do begin
      @(negedge i_clk_sys);
      n++;
      if (wp_n === 1'h0) wpc++;
      if (sv === 1'h1) svc++;
      if (bsy === 1'h1) bsc++;
    end while (done !== 1'h1 && refused !== 1'h1 && n < 3000);
    refd = refused;
    if (done !== 1'h1 && refused !== 1'h1) begin
      num_errors++;
      $display("[ERR] %0t request never finished", $time);
    end
  endtask
  task stat(input logic [7:0] exp);
    run(NBP_OP_STATUS);
    ex(1'h1, 8'h7a);
    ex_ba(lo, 1'h0);
    cmp_log();
    chk(9'(lock_st), 9'(exp));
    chk(9'(svc), 9'h001);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_sys_rst = 1'h1;
    req_valid = 1'h0;
    req_op = NBP_OP_UNLOCK;
    lo = 13'h0016;
    up = 13'h1abd;
    inv = 1'h1;
    grp = 4'h5;
    repeat (6) @(posedge i_clk_sys);
    i_sys_rst <= 1'h0;
    run(NBP_OP_UNLOCK);
    ex(1'h1, 8'h23);
    ex_ba(lo, 1'h0);
    ex(1'h1, 8'h24);
    ex_ba(up, inv);
    cmp_log();
    stat(8'h0a);
    run(NBP_OP_LOCK_ALL);
    ex(1'h1, 8'h2a);
    cmp_log();
    stat(8'h0a);
    run(NBP_OP_PERM);
    perm_exp(4'h0);
    cmp_log();
    run(NBP_OP_PERM);
    chk(9'(refd), 9'h001);
    chk(9'(bsc), 9'h000);
    cmp_log();
    chk({7'h00, wp_n, volatile_protect_enable_pin}, 9'h003);
    run(NBP_OP_LOCKDOWN);
    ex(1'h1, 8'h2c);
    cmp_log();
    run(NBP_OP_UNLOCK);
    ex(1'h1, 8'h23);
    ex_ba(lo, 1'h0);
    ex(1'h1, 8'h24);
    ex_ba(up, inv);
    cmp_log();
    stat(8'h01);
    grp <= 4'h3;
    run(NBP_OP_PERM_LD);
    perm_exp(4'h1);
    cmp_log();
    grp <= 4'h7;
    run(NBP_OP_PERM);
    chk(9'(refd), 9'h001);
    chk(9'(bsc), 9'h000);
    stat(8'h11);
    run(NBP_OP_WP_PULSE);
    chk(9'(wpc), 9'h004);
    wrap_up();
  end
endmodule
